// File: src/vec_unit_regs.vh
// constants for the vector address, bitwise and shift unit
`ifndef VEC_UNIT_REGS_VH
`define VEC_UNIT_REGS_VH

// vector register width in bits, and vector / predicate lengths in bytes
`define VLEN          128
`define VL_BYTES      64'd16
`define PL_BYTES      64'd2

// operation codes on op_i
`define OP_AND        5'h00
`define OP_BIT_CLEAR  5'h01
`define OP_EXCL_OR    5'h02
`define OP_INCL_OR    5'h03
`define OP_AND_IMM    5'h04
`define OP_BIC_IMM    5'h05
`define OP_EOR_IMM    5'h06
`define OP_ORR_IMM    5'h07
`define OP_XOR_INV    5'h08
`define OP_OR_INV     5'h09
`define OP_NOT        5'h0A
`define OP_BCAST      5'h0B
`define OP_MOVE       5'h0C
`define OP_ASR        5'h0D
`define OP_LSL        5'h0E
`define OP_LSR        5'h0F
`define OP_ARITH_SHIFT_DIVIDE       5'h10
`define OP_CLS        5'h11
`define OP_CLZ        5'h12
`define OP_POPCNT     5'h13
`define OP_BIT_REVERSE       5'h14
`define OP_ADR        5'h15
`define OP_ADD_VEC_LEN_MULTIPLE      5'h16
`define OP_ADD_PRED_LEN_MULTIPLE      5'h17
`define OP_READ_VEC_LEN_MULTIPLE       5'h18

// element function codes for the element unit
`define FN_ASR        3'h0
`define FN_LSL        3'h1
`define FN_LSR        3'h2
`define FN_ARITH_SHIFT_DIVIDE       3'h3
`define FN_CLS        3'h4
`define FN_CLZ        3'h5
`define FN_CNT        3'h6
`define FN_BIT_REVERSE       3'h7

// shift amount source on shift_src_i
`define SHS_IMM       2'h0
`define SHS_VEC       2'h1
`define SHS_WIDE      2'h2
`define SHS_REV       2'h3

// address modes on adr_mode_i
`define ADR_32        2'h0
`define ADR_64        2'h1
`define ADR_64_ZX     2'h2
`define ADR_64_SX     2'h3

`endif

// File: src/elem_bit_unit.v
// one element of shift, divide-shift, count and reverse logic
`timescale 1ns/10ps
`include "vec_unit_regs.vh"

module elem_bit_unit #(
  parameter W = 8
) (
  input  wire [W-1:0] val_i,  // element value
  input  wire [63:0]  amt_i,  // shift amount, all bits significant
  input  wire [2:0]   fn_i,   // element function
  output reg  [W-1:0] res_o   // element result
);

  integer          k;
  reg              sat;
  reg              done;
  reg  [5:0]       sh;
  reg  [6:0]       cnt;
  reg  [W+6:0]     cnt_ext;
  reg  [W-1:0]     bias;
  reg  [W-1:0]     biased;
  reg  signed [W-1:0] sval;
  reg  signed [W-1:0] sbiased;
  reg  [W-1:0]     asr_val;
  reg  [W-1:0]     arith_shift_divide_val;

  // combinational element function
  always @*
  begin
    sat     = (amt_i >= W);
    sh      = amt_i[5:0];
    cnt     = 7'h00;
    done    = 1'b0;
    bias    = ({{(W-1){1'b0}}, 1'b1} << sh) - {{(W-1){1'b0}}, 1'b1};
    biased  = val_i + (val_i[W-1] ? bias : {W{1'b0}});
    // signed shifts stand alone: inside a mixed ternary they would turn logical
    sval     = val_i;
    sbiased  = biased;
    asr_val  = sval >>> sh;
    arith_shift_divide_val = sbiased >>> sh;
    cnt_ext = {(W+7){1'b0}};
    res_o   = {W{1'b0}};
    case (fn_i)
      `FN_ASR:  res_o = sat ? {W{val_i[W-1]}} : asr_val;
      `FN_LSL:  res_o = sat ? {W{1'b0}} : (val_i << sh);
      `FN_LSR:  res_o = sat ? {W{1'b0}} : (val_i >> sh);
      // a shift of the full width rounds any value toward zero, so zero
      `FN_ARITH_SHIFT_DIVIDE: res_o = sat ? {W{1'b0}} : arith_shift_divide_val;
      `FN_CLS:
      begin
        for (k = W - 2; k >= 0; k = k - 1)
        begin
          if (!done && (val_i[k] == val_i[W-1]))
            cnt = cnt + 7'h01;
          else
            done = 1'b1;
        end
        cnt_ext = {{W{1'b0}}, cnt};
        res_o   = cnt_ext[W-1:0];
      end
      `FN_CLZ:
      begin
        for (k = W - 1; k >= 0; k = k - 1)
        begin
          if (!done && !val_i[k])
            cnt = cnt + 7'h01;
          else
            done = 1'b1;
        end
        cnt_ext = {{W{1'b0}}, cnt};
        res_o   = cnt_ext[W-1:0];
      end
      `FN_CNT:
      begin
        for (k = 0; k < W; k = k + 1)
          cnt = cnt + {6'h00, val_i[k]};
        cnt_ext = {{W{1'b0}}, cnt};
        res_o   = cnt_ext[W-1:0];
      end
      default:
      begin
        for (k = 0; k < W; k = k + 1)
          res_o[k] = val_i[W-1-k];
      end
    endcase
  end

endmodule // elem_bit_unit

// File: src/vector_addr_bitwise_shift_unit.v
// vector address, bitwise logic, shift and count execution unit
//
// Summary of operation
// - address element is base plus index element
// - index optionally extended, then shifted zero-three
// - 32-bit addresses use unsigned 32-bit index
// - 64-bit addresses: full, zero- or sign-extended index
// - scalar plus immediate times vector length
// - scalar plus immediate times predicate length
// - scalar gets immediate times vector length
// - unpredicated logic ignores element size
// - and, clear, xor, or: vector or immediate
// - xor/or inverted immediate, whole-vector invert
// - broadcast bitmask immediate; register move
// - oversize shift counts saturate, never wrap
// - wide shift uses aligned 64-bit amount
// - all 64 amount bits decide saturation
// - shifts by immediate, wide and vector
// - reversed shifts swap value and amount
// - separate divide-rounding arithmetic right shift
// - leading sign, leading zero, popcount, bit reverse
`timescale 1ns/10ps
`include "vec_unit_regs.vh"

module vector_addr_bitwise_shift_unit (
  input  wire                 core_clk_i,   // core clock, 40 MHz
  input  wire                 rst_i,        // synchronous reset, active high
  input  wire                 valid_i,      // operation issued this cycle
  input  wire [4:0]           op_i,         // operation code
  input  wire [1:0]           esize_i,      // element size: 0=8 1=16 2=32 3=64
  input  wire                 pred_en_i,    // predicated form
  input  wire [15:0]          pred_i,       // governing predicate, one bit per byte
  input  wire [`VLEN-1:0]     src_a_i,      // first source vector / address base
  input  wire [`VLEN-1:0]     src_b_i,      // second source vector / address index
  input  wire [`VLEN-1:0]     dst_old_i,    // prior destination, for merging
  input  wire [63:0]          imm_i,        // decoded bitmask immediate
  input  wire [6:0]           shamt_imm_i,  // shift immediate
  input  wire [1:0]           shift_src_i,  // shift amount source
  input  wire [1:0]           adr_mode_i,   // address element mode
  input  wire [1:0]           adr_shift_i,  // index left shift, 0 to 3
  input  wire [63:0]          gpr_i,        // scalar source register
  input  wire [5:0]           len_imm_i,    // signed length multiplier
  output reg                  valid_o,      // result valid, one cycle pulse
  output reg                  vec_we_o,     // vector result write enable
  output reg                  gpr_we_o,     // scalar result write enable
  output reg  [`VLEN-1:0]     vec_res_o,    // vector result
  output reg  [63:0]          gpr_res_o     // scalar result
);

  localparam NW64 = `VLEN / 64;
  localparam NW32 = `VLEN / 32;

  wire [`VLEN-1:0] imm_rep;
  wire [`VLEN-1:0] adr32;
  wire [`VLEN-1:0] adr64;
  wire [`VLEN-1:0] sh_res [0:3];
  wire [`VLEN-1:0] merge_mask;
  wire [`VLEN-1:0] val_src;
  wire [`VLEN-1:0] amt_src;
  wire [63:0]      len_mult;
  wire [63:0]      vl_prod;
  wire [63:0]      pl_prod;
  reg  [2:0]       fn;
  reg  [`VLEN-1:0] raw;
  reg              use_pred;
  reg              next_vec_we;
  reg              next_gpr_we;
  reg  [`VLEN-1:0] next_vec;
  reg  [63:0]      next_gpr;

  // bitmask immediate copied into every 64-bit slot of the vector
  assign imm_rep = {NW64{imm_i}};

  // reversed forms take the value from the second source
  assign val_src = (shift_src_i == `SHS_REV) ? src_b_i : src_a_i;
  assign amt_src = (shift_src_i == `SHS_REV) ? src_a_i : src_b_i;

  // 32-bit address elements: base plus scaled unsigned index
  genvar g;
  generate
    for (g = 0; g < NW32; g = g + 1)
    begin : g_adr32
      assign adr32[g*32 +: 32] = src_a_i[g*32 +: 32]
                               + (src_b_i[g*32 +: 32] << adr_shift_i);
    end
  endgenerate

  // 64-bit address elements: index full, zero- or sign-extended, then scaled
  generate
    for (g = 0; g < NW64; g = g + 1)
    begin : g_adr64
      wire [63:0] idx;
      assign idx = (adr_mode_i == `ADR_64_ZX) ? {32'h00000000, src_b_i[g*64 +: 32]} :
                   (adr_mode_i == `ADR_64_SX) ? {{32{src_b_i[g*64+31]}},
                                                 src_b_i[g*64 +: 32]} :
                   src_b_i[g*64 +: 64];
      assign adr64[g*64 +: 64] = src_a_i[g*64 +: 64] + (idx << adr_shift_i);
    end
  endgenerate

  // element units for every size; the issued size picks one result
  genvar s;
  genvar e;
  generate
    for (s = 0; s < 4; s = s + 1)
    begin : g_size
      localparam W  = 8 << s;
      localparam NE = `VLEN / W;
      for (e = 0; e < NE; e = e + 1)
      begin : g_elem
        wire [W+63:0] amt_ext;
        wire [63:0]   amt;
        assign amt_ext = {64'h0000000000000000, amt_src[e*W +: W]};
        // wide amount comes from the 64-bit slot covering this element
        assign amt = (shift_src_i == `SHS_IMM)  ? {57'h000000000000000, shamt_imm_i} :
                     (shift_src_i == `SHS_WIDE) ? src_b_i[((e*W)/64)*64 +: 64] :
                     amt_ext[63:0];
        elem_bit_unit #(
          .W      (W)
        ) u_elem (
          .val_i  (val_src[e*W +: W]),
          .amt_i  (amt),
          .fn_i   (fn),
          .res_o  (sh_res[s][e*W +: W])
        );
      end
    end
  endgenerate

  // byte enable: an element is active when the predicate bit of its lowest byte is set
  generate
    for (g = 0; g < 16; g = g + 1)
    begin : g_mask
      wire act;
      assign act = (esize_i == 2'h0) ? pred_i[g] :
                   (esize_i == 2'h1) ? pred_i[g & 14] :
                   (esize_i == 2'h2) ? pred_i[g & 12] : pred_i[g & 8];
      assign merge_mask[g*8 +: 8] = {8{act | ~use_pred}};
    end
  endgenerate

  // length multiples for the scalar length operations
  assign len_mult = {{58{len_imm_i[5]}}, len_imm_i};
  assign vl_prod  = len_mult * `VL_BYTES;
  assign pl_prod  = len_mult * `PL_BYTES;

  // element function from the operation code
  always @*
  begin
    case (op_i)
      `OP_LSL:    fn = `FN_LSL;
      `OP_LSR:    fn = `FN_LSR;
      `OP_ARITH_SHIFT_DIVIDE:   fn = `FN_ARITH_SHIFT_DIVIDE;
      `OP_CLS:    fn = `FN_CLS;
      `OP_CLZ:    fn = `FN_CLZ;
      `OP_POPCNT: fn = `FN_CNT;
      `OP_BIT_REVERSE:   fn = `FN_BIT_REVERSE;
      default:    fn = `FN_ASR;
    endcase
  end

  // result selection; logic ops act on the whole register, whatever the size
  always @*
  begin
    raw         = {`VLEN{1'b0}};
    next_gpr    = 64'h0000000000000000;
    next_vec_we = 1'b1;
    next_gpr_we = 1'b0;
    use_pred    = pred_en_i;
    case (op_i)
      `OP_AND:       raw = src_a_i & src_b_i;
      `OP_BIT_CLEAR: raw = src_a_i & ~src_b_i;
      `OP_EXCL_OR:   raw = src_a_i ^ src_b_i;
      `OP_INCL_OR:   raw = src_a_i | src_b_i;
      `OP_AND_IMM:   raw = src_a_i & imm_rep;
      `OP_BIC_IMM:   raw = src_a_i & ~imm_rep;
      `OP_EOR_IMM:   raw = src_a_i ^ imm_rep;
      `OP_ORR_IMM:   raw = src_a_i | imm_rep;
      `OP_XOR_INV:   raw = src_a_i ^ ~imm_rep;
      `OP_OR_INV:    raw = src_a_i | ~imm_rep;
      `OP_NOT:       raw = ~src_a_i;
      `OP_BCAST:
      begin
        raw      = imm_rep;
        use_pred = 1'b0;
      end
      `OP_MOVE:      raw = src_a_i;
      `OP_ASR, `OP_LSL, `OP_LSR, `OP_ARITH_SHIFT_DIVIDE,
      `OP_CLS, `OP_CLZ, `OP_POPCNT, `OP_BIT_REVERSE:
                     raw = sh_res[esize_i];
      `OP_ADR:
      begin
        raw      = (adr_mode_i == `ADR_32) ? adr32 : adr64;
        use_pred = 1'b0;
      end
      `OP_ADD_VEC_LEN_MULTIPLE:
      begin
        next_gpr    = gpr_i + vl_prod;
        next_vec_we = 1'b0;
        next_gpr_we = 1'b1;
      end
      `OP_ADD_PRED_LEN_MULTIPLE:
      begin
        next_gpr    = gpr_i + pl_prod;
        next_vec_we = 1'b0;
        next_gpr_we = 1'b1;
      end
      `OP_READ_VEC_LEN_MULTIPLE:
      begin
        next_gpr    = vl_prod;
        next_vec_we = 1'b0;
        next_gpr_we = 1'b1;
      end
      default:
      begin
        next_vec_we = 1'b0;
      end
    endcase
    // inactive elements carry the old destination through
    next_vec = (raw & merge_mask) | (dst_old_i & ~merge_mask);
  end

  // single result register stage; unknown codes produce no write
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      valid_o   <= 1'b0;
      vec_we_o  <= 1'b0;
      gpr_we_o  <= 1'b0;
      vec_res_o <= {`VLEN{1'b0}};
      gpr_res_o <= 64'h0000000000000000;
    end
    else
    begin
      valid_o  <= valid_i;
      vec_we_o <= valid_i & next_vec_we;
      gpr_we_o <= valid_i & next_gpr_we;
      if (valid_i)
      begin
        vec_res_o <= next_vec;
        gpr_res_o <= next_gpr;
      end
    end
  end

endmodule // vector_addr_bitwise_shift_unit

// File: dv/vec_unit_props.sv
// port-level assertions for the vector unit
`timescale 1ns/10ps
`include "vec_unit_regs.vh"
module vec_unit_props (
  input wire             core_clk_i,  // clock
  input wire             rst_i,       // reset
  input wire             valid_i,     // issue
  input wire [4:0]       op_i,        // opcode
  input wire             pred_en_i,   // predicated
  input wire [15:0]      pred_i,      // predicate
  input wire [`VLEN-1:0] src_a_i,     // source a
  input wire [`VLEN-1:0] src_b_i,     // source b
  input wire [`VLEN-1:0] dst_old_i,   // old dest
  input wire [63:0]      imm_i,       // bitmask
  input wire [1:0]       adr_mode_i,  // adr mode
  input wire [1:0]       adr_shift_i, // adr scale
  input wire [63:0]      gpr_i,       // scalar in
  input wire [5:0]       len_imm_i,   // multiplier
  input wire             valid_o,     // done
  input wire             vec_we_o,    // vector write
  input wire             gpr_we_o,    // scalar write
  input wire [`VLEN-1:0] vec_res_o,   // vector out
  input wire [63:0]      gpr_res_o    // scalar out
);
  // multiplier is signed, so widen with its sign before scaling
  wire [63:0] len_ext = {{58{len_imm_i[5]}}, len_imm_i};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_answer; valid_i |=> valid_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer after issue");
  property p_add_vl; valid_i && op_i == `OP_ADD_VEC_LEN_MULTIPLE |=> gpr_we_o &&
    gpr_res_o == $past(gpr_i) + $past(len_ext) * `VL_BYTES; endproperty
  a_add_vl: assert property (p_add_vl)
    else $error("vector length add wrong");
  property p_add_pl; valid_i && op_i == `OP_ADD_PRED_LEN_MULTIPLE |=> gpr_we_o &&
    gpr_res_o == $past(gpr_i) + $past(len_ext) * `PL_BYTES; endproperty
  a_add_pl: assert property (p_add_pl)
    else $error("predicate length add wrong");
  property p_read_vl; valid_i && op_i == `OP_READ_VEC_LEN_MULTIPLE |=> gpr_we_o &&
    gpr_res_o == $past(len_ext) * `VL_BYTES; endproperty
  a_read_vl: assert property (p_read_vl)
    else $error("vector length read wrong");
  property p_and; valid_i && op_i == `OP_AND && !pred_en_i |=> vec_we_o &&
    vec_res_o == $past(src_a_i & src_b_i); endproperty
  a_and: assert property (p_and)
    else $error("unpredicated and wrong");
  property p_not; valid_i && op_i == `OP_NOT && !pred_en_i |=>
    vec_res_o == ~$past(src_a_i); endproperty
  a_not: assert property (p_not)
    else $error("invert wrong");
  property p_bcast; valid_i && op_i == `OP_BCAST |=>
    vec_res_o == {2{$past(imm_i)}}; endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast wrong");
  property p_keep; valid_i && op_i == `OP_MOVE && pred_en_i && pred_i == 16'h0000 |=>
    vec_res_o == $past(dst_old_i); endproperty
  a_keep: assert property (p_keep)
    else $error("inactive elements changed");
  property p_adr64; valid_i && op_i == `OP_ADR && adr_mode_i == `ADR_64 |=>
    vec_res_o[63:0] == $past(src_a_i[63:0] + (src_b_i[63:0] << adr_shift_i)); endproperty
  a_adr64: assert property (p_adr64)
    else $error("64-bit address wrong");
endmodule // vec_unit_props

// File: dv/result_sink.sv
// writeback model: register-file write ports behind the unit
`timescale 1ns/10ps
module result_sink (
  input  wire         core_clk_i, // clock
  input  wire         rst_i,      // reset
  input  wire         vec_we_i,   // vector write
  input  wire         gpr_we_i,   // scalar write
  input  wire [127:0] vec_i,      // vector data
  input  wire [63:0]  gpr_i,      // scalar data
  output reg  [127:0] vec_q_o,    // last vector stored
  output reg  [63:0]  gpr_q_o     // last scalar stored
);
  // store only on an enable, so a missing write shows as stale data
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      vec_q_o <= 128'h0;
      gpr_q_o <= 64'h0;
    end
    else
    begin
      if (vec_we_i) vec_q_o <= vec_i;
      if (gpr_we_i) gpr_q_o <= gpr_i;
    end
  end
endmodule // result_sink

// File: dv/test_vector_addr_bitwise_shift_unit.sv
// self-checking bench for the vector address, bitwise and shift unit
`timescale 1ns/10ps
`include "vec_unit_regs.vh"
module test_vector_addr_bitwise_shift_unit;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg valid_i = 1'b0, pred_en_i = 1'b0;
  reg [4:0] op_i = 5'h00;
  reg [1:0] esize_i = 2'h0, shift_src_i = 2'h0, adr_mode_i = 2'h0, adr_shift_i = 2'h0;
  reg [15:0] pred_i = 16'h0000;
  reg [127:0] src_a_i = 128'h0, src_b_i = 128'h0, dst_old_i = 128'h0;
  reg [63:0] imm_i = 64'h0, gpr_i = 64'h0;
  reg [6:0] shamt_imm_i = 7'h00;
  reg [5:0] len_imm_i = 6'h00;
  wire valid_o, vec_we_o, gpr_we_o;
  wire [127:0] vec_res_o, vq;
  wire [63:0] gpr_res_o, gq;
  integer fail_count = 0, compares = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  vector_addr_bitwise_shift_unit vector_addr_bitwise_shift_unit_inst (.core_clk_i, .rst_i,
    .valid_i, .op_i, .esize_i, .pred_en_i, .pred_i, .src_a_i, .src_b_i, .dst_old_i, .imm_i,
    .shamt_imm_i, .shift_src_i, .adr_mode_i, .adr_shift_i, .gpr_i, .len_imm_i, .valid_o,
    .vec_we_o, .gpr_we_o, .vec_res_o, .gpr_res_o);
  result_sink result_sink_inst (.core_clk_i, .rst_i, .vec_we_i(vec_we_o),
    .gpr_we_i(gpr_we_o), .vec_i(vec_res_o), .gpr_i(gpr_res_o), .vec_q_o(vq), .gpr_q_o(gq));
  task close_out;
  begin
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task check(input [127:0] got, input [127:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // one issue pulse; the answer is due on the very next edge
  task issue(input [4:0] code, input vec);
  begin
    @(posedge core_clk_i);
    #1 valid_i = 1'b1;
    op_i = code;
    @(posedge core_clk_i);
    #1 valid_i = 1'b0;
    check({valid_o, vec_we_o, gpr_we_o}, {1'b1, vec, ~vec});
    @(posedge core_clk_i);
    #1;
  end
  endtask
  task el_case(input [4:0] code, input [1:0] src, input [6:0] amt,
               input [127:0] va, input [127:0] vb, input [127:0] ve);
  begin
    shift_src_i = src;
    shamt_imm_i = amt;
    src_a_i = va;
    src_b_i = vb;
    issue(code, 1'b1);
    check(vq, ve);
  end
  endtask
  // all logic codes 0x00..0x0C, element size varied to show it is ignored
  task t_logic;
    reg [127:0] a, b, m, e;
    integer i;
  begin
    a = {4{32'h0F0F_A5C3}};
    b = {4{32'h3355_FF00}};
    imm_i = 64'h00FF_F0F0_1234_8001;
    m = {2{imm_i}};
    for (i = 0; i < 13; i = i + 1)
    begin
      esize_i = i[1:0];
      case (i)
        0: e = a & b;
        1: e = a & ~b;
        2: e = a ^ b;
        3: e = a | b;
        4: e = a & m;
        5: e = a & ~m;
        6: e = a ^ m;
        7: e = a | m;
        8: e = a ^ ~m;
        9: e = a | ~m;
        10: e = ~a;
        11: e = m;
        default: e = a;
      endcase
      el_case(i[4:0], `SHS_IMM, 7'h00, a, b, e);
    end
  end
  endtask
  // half the bytes inactive, then every element inactive
  task t_pred;
  begin
    esize_i = 2'h0;
    pred_en_i = 1'b1;
    dst_old_i = {16{8'h77}};
    pred_i = 16'h00FF;
    el_case(`OP_AND, `SHS_IMM, 7'h00, {16{8'h3C}}, {16{8'hF0}}, {{8{8'h77}}, {8{8'h30}}});
    pred_i = 16'h0000;
    el_case(`OP_MOVE, `SHS_IMM, 7'h00, {16{8'h12}}, 128'h0, {16{8'h77}});
    pred_en_i = 1'b0;
  end
  endtask
  task t_shift;
  begin
    esize_i = 2'h0;
    el_case(`OP_LSL, `SHS_IMM, 7'h09, {16{8'hF0}}, 128'h0, 128'h0);
    el_case(`OP_ASR, `SHS_IMM, 7'h08, {16{8'h80}}, 128'h0, {16{8'hFF}});
    el_case(`OP_LSR, `SHS_WIDE, 7'h00, {16{8'hF0}}, {64'h2, 64'h1_0000_0001},
            {{8{8'h3C}}, {8{8'h00}}});
    el_case(`OP_ASR, `SHS_VEC, 7'h00, {16{8'h90}}, {16{8'h02}}, {16{8'hE4}});
    el_case(`OP_LSL, `SHS_REV, 7'h00, {16{8'h01}}, {16{8'h81}}, {16{8'h02}});
    el_case(`OP_ARITH_SHIFT_DIVIDE, `SHS_IMM, 7'h01, {16{8'hF9}}, 128'h0, {16{8'hFD}});
    el_case(`OP_CLS, `SHS_IMM, 7'h00, {16{8'h0F}}, 128'h0, {16{8'h03}});
    el_case(`OP_CLZ, `SHS_IMM, 7'h00, {16{8'h0F}}, 128'h0, {16{8'h04}});
    el_case(`OP_POPCNT, `SHS_IMM, 7'h00, {16{8'h0F}}, 128'h0, {16{8'h04}});
    el_case(`OP_BIT_REVERSE, `SHS_IMM, 7'h00, {16{8'h0F}}, 128'h0, {16{8'hF0}});
  end
  endtask
  task adr_case(input [1:0] mode, input [1:0] sh, input [127:0] va, input [127:0] vb,
                input [127:0] ve);
  begin
    adr_mode_i = mode;
    adr_shift_i = sh;
    el_case(`OP_ADR, `SHS_IMM, 7'h00, va, vb, ve);
  end
  endtask
  task t_adr;
  begin
    adr_case(`ADR_32, 2'h2, {4{32'h1000}}, {4{32'hFFFF_FFFF}}, {4{32'h0FFC}});
    adr_case(`ADR_64, 2'h0, {2{64'h1000}}, {2{64'hFFFF_FFFF_0000_0001}},
             {2{64'hFFFF_FFFF_0000_1001}});
    adr_case(`ADR_64_ZX, 2'h3, {2{64'h1000}}, {2{64'hAAAA_AAAA_FFFF_FFFF}},
             {2{64'h8_0000_0FF8}});
    adr_case(`ADR_64_SX, 2'h1, {2{64'h1000}}, {2{64'hAAAA_AAAA_FFFF_FFFF}},
             {2{64'h0FFE}});
  end
  endtask
  task len_case(input [4:0] code, input [5:0] mult, input [63:0] ge);
  begin
    gpr_i = 64'h100;
    len_imm_i = mult;
    issue(code, 1'b0);
    check({64'h0, gq}, {64'h0, ge});
  end
  endtask
  task t_len;
  begin
    len_case(`OP_ADD_VEC_LEN_MULTIPLE, 6'h3F, 64'hF0);
    len_case(`OP_ADD_PRED_LEN_MULTIPLE, 6'h1F, 64'h13E);
    len_case(`OP_READ_VEC_LEN_MULTIPLE, 6'h20, 64'hFFFF_FFFF_FFFF_FE00);
  end
  endtask
  // watchdog: the whole run is far shorter than this bound
  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    fail_count = fail_count + 1;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    t_logic;
    t_pred;
    t_shift;
    t_adr;
    t_len;
    close_out;
  end
endmodule // test_vector_addr_bitwise_shift_unit
bind vector_addr_bitwise_shift_unit vec_unit_props vec_unit_props_inst (.core_clk_i, .rst_i,
  .valid_i, .op_i, .pred_en_i, .pred_i, .src_a_i, .src_b_i, .dst_old_i, .imm_i, .adr_mode_i,
  .adr_shift_i, .gpr_i, .len_imm_i, .valid_o, .vec_we_o, .gpr_we_o, .vec_res_o, .gpr_res_o);
